// File: common/dpl_pkg.sv
// Package with register map, field layout, timing and carrier types for the DRAM power cap block.
package dpl_pkg;

  // ************************************************************
  // Register map: each 64-bit register is two aligned 32-bit words.
  // ************************************************************
  localparam logic [7:0] CAP_CTRL_LO   = 8'h00;
  localparam logic [7:0] CAP_CTRL_HI   = 8'h04;
  localparam logic [7:0] ENERGY_LO     = 8'h08;
  localparam logic [7:0] ENERGY_HI     = 8'h0C;
  localparam logic [7:0] RANGE_LO      = 8'h10;
  localparam logic [7:0] RANGE_HI      = 8'h14;
  localparam logic [7:0] THROTTLE_LO   = 8'h18;
  localparam logic [7:0] THROTTLE_HI   = 8'h1C;
  localparam logic [7:0] SAMPLE_REG    = 8'h20;
  localparam logic [7:0] STATUS_REG    = 8'h24;

  // ************************************************************
  // Field positions.
  // ************************************************************
  localparam int LIMIT_LSB   = 0;
  localparam int LIMIT_MSB   = 14;
  localparam int ENABLE_BIT  = 15;
  localparam int WIN_LSB     = 17;
  localparam int WIN_MSB     = 23;
  localparam int WIN_EXP_MSB = 21;
  localparam int WIN_FRAC_LSB = 22;
  localparam int LOCK_BIT    = 31;
  localparam logic [31:0] CAP_CTRL_WMASK = 32'h80FE_FFFF;
  localparam logic [31:0] CAP_CTRL_RESET = 32'h0000_0000;

  // ************************************************************
  // Power range values, arbitrary defaults.
  // ************************************************************
  localparam logic [14:0] TDP_POWER   = 15'h0100;
  localparam logic [14:0] MIN_POWER   = 15'h0040;
  localparam logic [14:0] MAX_POWER   = 15'h0200;
  localparam logic [5:0]  MAX_WINDOW  = 6'h2A;

  // ************************************************************
  // Timing.
  // ************************************************************
  localparam int CLK_HZ          = 10_000_000;
  localparam int TIME_UNIT_NS    = 1000;
  localparam int REFRESH_US      = 1000;
  localparam int REFRESH_CYCLES  = REFRESH_US * (CLK_HZ / 1_000_000);
  localparam int UNIT_CYCLES     = TIME_UNIT_NS / (1_000_000_000 / CLK_HZ);
  localparam int UNIT_CNT_W      = 8;

  typedef struct packed {
    logic        lock;
    logic [6:0]  window;
    logic        enable;
    logic [14:0] limit;
  } dpl_cap_t;

  typedef struct packed {
    logic [15:0] power;
    logic        throttle_req;
  } dpl_sense_t;

endpackage : dpl_pkg

// File: src/dpl_window_avg.sv
// Averaging window engine that compares window energy against the cap.
module dpl_window_avg (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire dpl_pkg::dpl_cap_t cap,
  input  wire logic              unit_tick,
  input  wire logic [15:0]       power,
  output logic                   over_limit
);

  logic [4:0]  exp_y;
  logic [1:0]  frac_z;
  logic [39:0] span;
  logic [39:0] elapsed;
  logic [55:0] energy_acc;
  logic [55:0] budget;

  assign exp_y  = cap.window[4:0];
  assign frac_z = cap.window[6:5];
  // Window length is 2^Y times (1 + Z/10); tenths come from a truncating integer divide by ten.
  assign span   = (40'h1 << exp_y) + ((40'(frac_z) << exp_y) / 40'hA);
  assign budget = 56'(cap.limit) * 56'(span);

  // ************************************************************
  // Window accumulation: the decision is latched at each window end.
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      elapsed    <= 40'h0;
      energy_acc <= 56'h0;
      over_limit <= 1'b0;
    end else if (!cap.enable) begin
      elapsed    <= 40'h0;
      energy_acc <= 56'h0;
      over_limit <= 1'b0;
    end else if (unit_tick) begin
      if (elapsed + 40'h1 >= span) begin
        over_limit <= (energy_acc + 56'(power)) > budget; // see RQ5
        elapsed    <= 40'h0;
        energy_acc <= 56'h0;
      end else begin
        elapsed    <= elapsed + 40'h1;
        energy_acc <= energy_acc + 56'(power);
      end
    end
  end

endmodule : dpl_window_avg

// File: src/dpl_regs.sv
// APB register bank for the DRAM running average power limiting domain.
// What this block does
// RQ1 - Cap control bits 14:0 hold the DRAM average power limit.
// RQ2 - Cap control bit 15 enables the limit when one, disables when zero.
// RQ3 - Window bits 23:17 mean 2^Y times 1.Z, Y bits 21:17, Z bits 23:22.
// RQ4 - Once lock bit 31 is set, writes to cap control are dropped until reset.
// RQ5 - An enabled cap is applied to average power over the encoded window.
// RQ6 - Energy counter is read-only, unsigned energy in bits 31:0.
// RQ7 - Energy counter is refreshed about once every millisecond.
// RQ8 - Range info bits 14:0 give thermal specification power.
// RQ9 - Range info bits 30:16 give minimum power.
// RQ10 - Range info bits 46:32 give maximum power.
// RQ11 - Range info bits 53:48 give the largest legal averaging window.
// RQ12 - Throttle time counter accumulates throttled time units in bits 31:0.
// RQ13 - Only time held below the requested performance state counts.
// RQ14 - Throttle counter runs many hours before wrapping; the 32-bit microsecond count here wraps after about 71 minutes.
// RQ15 - Both counters wrap from all ones to zero silently.
module dpl_regs (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  input  wire logic [3:0]          pstrb,
  output logic                     pready,
  output logic [31:0]              prdata,
  output logic                     pslverr,
  input  wire dpl_pkg::dpl_sense_t sense_in,
  output logic                     throttle_out,
  output logic                     cap_active
);

  // ************************************************************
  // Input synchronisers and state.
  // ************************************************************
  localparam int UNIT_W = dpl_pkg::UNIT_CNT_W;

  dpl_pkg::dpl_sense_t sense_meta;
  dpl_pkg::dpl_sense_t sense;
  dpl_pkg::dpl_cap_t   cap;
  logic [31:0]         energy_live;
  logic [31:0]         energy_shown;
  logic [31:0]         throttle_time;
  logic [31:0]         refresh_cnt;
  logic [UNIT_W-1:0]   unit_cnt;
  logic                unit_tick;
  logic                over_limit;
  logic                wr_cap;
  logic                access;
  logic [31:0]         next_prdata;
  logic                next_pslverr;

  function automatic logic known_addr(input logic [7:0] a);
    known_addr = (a <= dpl_pkg::STATUS_REG) && (a[1:0] == 2'b00);
  endfunction : known_addr

  // Reserved bits read as zero so that software never sees stale or undefined values.
  function automatic logic [31:0] cap_word(input dpl_pkg::dpl_cap_t c);
    cap_word = {c.lock, 7'h00, c.window, 1'b0, c.enable, c.limit};
  endfunction : cap_word

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sense_meta <= '0;
      sense      <= '0;
    end else begin
      sense_meta <= sense_in;
      sense      <= sense_meta;
    end
  end

  // ************************************************************
  // Time unit tick and energy refresh period.
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unit_cnt  <= '0;
      unit_tick <= 1'b0;
    end else if (unit_cnt == UNIT_W'(dpl_pkg::UNIT_CYCLES - 1)) begin
      unit_cnt  <= '0;
      unit_tick <= 1'b1;
    end else begin
      unit_cnt  <= unit_cnt + UNIT_W'(1);
      unit_tick <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      refresh_cnt <= 32'h0;
    end else if (refresh_cnt == 32'(dpl_pkg::REFRESH_CYCLES - 1)) begin
      refresh_cnt <= 32'h0;
    end else begin
      refresh_cnt <= refresh_cnt + 32'h1;
    end
  end

  // ************************************************************
  // Energy counting: live sum per time unit, shown value per period.
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      energy_live  <= 32'h0;
      energy_shown <= 32'h0;
    end else begin
      if (unit_tick) begin
        energy_live <= energy_live + 32'(sense.power); // see RQ15
      end
      if (refresh_cnt == 32'(dpl_pkg::REFRESH_CYCLES - 1)) begin
        energy_shown <= energy_live; // see RQ7
      end
    end
  end

  // ************************************************************
  // Throttle time: one count per time unit held below request.
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      throttle_time <= 32'h0;
    end else if (unit_tick && throttle_out && sense.throttle_req) begin
      throttle_time <= throttle_time + 32'h1; // see RQ13 see RQ15
    end
  end

  // Thirty-two bits of one microsecond units wrap after over an hour. see RQ14

  // ************************************************************
  // Cap control register with lock.
  // ************************************************************
  assign access = psel && penable;
  assign wr_cap = access && pwrite && (paddr == dpl_pkg::CAP_CTRL_LO) && !cap.lock;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap.limit  <= dpl_pkg::CAP_CTRL_RESET[dpl_pkg::LIMIT_MSB:dpl_pkg::LIMIT_LSB];
      cap.enable <= dpl_pkg::CAP_CTRL_RESET[dpl_pkg::ENABLE_BIT];
      cap.window <= dpl_pkg::CAP_CTRL_RESET[dpl_pkg::WIN_MSB:dpl_pkg::WIN_LSB];
      cap.lock   <= dpl_pkg::CAP_CTRL_RESET[dpl_pkg::LOCK_BIT];
    end else if (wr_cap) begin // see RQ4
      if (pstrb[0]) begin
        cap.limit[7:0] <= pwdata[7:0]; // see RQ1
      end
      if (pstrb[1]) begin
        cap.limit[14:8] <= pwdata[14:8];
        cap.enable      <= pwdata[dpl_pkg::ENABLE_BIT]; // see RQ2
      end
      if (pstrb[2]) begin
        cap.window <= pwdata[dpl_pkg::WIN_MSB:dpl_pkg::WIN_LSB]; // see RQ3
      end
      if (pstrb[3]) begin
        cap.lock <= pwdata[dpl_pkg::LOCK_BIT];
      end
    end
  end

  dpl_window_avg u_avg (
    .pclk       (pclk),
    .presetn    (presetn),
    .cap        (cap),
    .unit_tick  (unit_tick),
    .power      (sense.power),
    .over_limit (over_limit)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      throttle_out <= 1'b0;
      cap_active   <= 1'b0;
    end else begin
      throttle_out <= cap.enable && over_limit; // see RQ5
      cap_active   <= cap.enable;
    end
  end

  // ************************************************************
  // Read path. Zero wait states keep the slave simple.
  // ************************************************************
  always_comb begin
    next_prdata  = 32'h0;
    next_pslverr = !known_addr(paddr);
    unique case (paddr)
      dpl_pkg::CAP_CTRL_LO: next_prdata = cap_word(cap); // see RQ3
      dpl_pkg::ENERGY_LO:   next_prdata = energy_shown; // see RQ6
      dpl_pkg::RANGE_LO:    next_prdata = {1'b0, dpl_pkg::MIN_POWER, 1'b0,
                                           dpl_pkg::TDP_POWER}; // see RQ8 see RQ9
      dpl_pkg::RANGE_HI:    next_prdata = {10'h0, dpl_pkg::MAX_WINDOW, 1'b0,
                                           dpl_pkg::MAX_POWER}; // see RQ10 see RQ11
      dpl_pkg::THROTTLE_LO: next_prdata = throttle_time; // see RQ12
      dpl_pkg::SAMPLE_REG:  next_prdata = {15'h0, sense.throttle_req, sense.power};
      dpl_pkg::STATUS_REG:  next_prdata = {29'h0, cap.lock, throttle_out, over_limit};
      default:              next_prdata = 32'h0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      pready  <= 1'b1;
      prdata  <= pwrite ? 32'h0 : next_prdata;
      pslverr <= next_pslverr;
    end else begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end
  end

  // ************************************************************
  // Checks.
  // ************************************************************
  lock_holds_a: assert property (@(posedge pclk) disable iff (!presetn) // see RQ4
    $past(cap.lock) |-> (cap == $past(cap)))
    else $error("Locked cap control changed.");

  enable_off_a: assert property (@(posedge pclk) disable iff (!presetn) // see RQ2
    !cap.enable |=> ##1 !throttle_out)
    else $error("Throttle asserted with cap disabled.");

  cap_write_a: assert property (@(posedge pclk) disable iff (!presetn) // see RQ1
    (wr_cap && pstrb == 4'hF) |=> (cap.limit == $past(pwdata[14:0])))
    else $error("Limit field not written.");

  window_write_a: assert property (@(posedge pclk) disable iff (!presetn) // see RQ3
    (wr_cap && pstrb[2]) |=> (cap.window == $past(pwdata[23:17])))
    else $error("Window field not written.");

  energy_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // see RQ7
    (refresh_cnt != 32'(dpl_pkg::REFRESH_CYCLES - 1)) |=> $stable(energy_shown))
    else $error("Energy value moved between refreshes.");

  throttle_gate_a: assert property (@(posedge pclk) disable iff (!presetn) // see RQ13
    !(throttle_out && sense.throttle_req) |=> $stable(throttle_time))
    else $error("Throttle time counted while not throttled.");

  throttle_step_a: assert property (@(posedge pclk) disable iff (!presetn) // see RQ15
    (unit_tick && throttle_out && sense.throttle_req)
      |=> (throttle_time == $past(throttle_time) + 32'h1))
    else $error("Throttle time did not step by one.");

  range_read_a: assert property (@(posedge pclk) disable iff (!presetn) // see RQ8
    (psel && !penable && !pwrite && paddr == dpl_pkg::RANGE_LO)
      |=> (prdata[14:0] == dpl_pkg::TDP_POWER && prdata[30:16] == dpl_pkg::MIN_POWER))
    else $error("Range info read wrong.");

  energy_read_a: assert property (@(posedge pclk) disable iff (!presetn) // see RQ6
    (psel && !penable && !pwrite && paddr == dpl_pkg::ENERGY_LO)
      |=> (prdata == $past(energy_shown)))
    else $error("Energy read wrong.");

  // ************************************************************
  // Register field checks.
  // ************************************************************
  cap_read_a: assert property (@(posedge pclk) disable iff (!presetn) // see RQ3
    (psel && !penable && !pwrite && paddr == dpl_pkg::CAP_CTRL_LO)
      |=> (prdata == {$past(cap.lock), 7'h00, $past(cap.window), 1'b0, $past(cap.enable),
                      $past(cap.limit)}))
    else $error("Cap control read wrong.");

  enable_write_a: assert property (@(posedge pclk) disable iff (!presetn) // see RQ2
    (wr_cap && pstrb[1])
      |=> (cap.enable == $past(pwdata[dpl_pkg::ENABLE_BIT])))
    else $error("Enable bit not written.");

  lock_write_a: assert property (@(posedge pclk) disable iff (!presetn) // see RQ4
    (wr_cap && pstrb[3])
      |=> (cap.lock == $past(pwdata[dpl_pkg::LOCK_BIT])))
    else $error("Lock bit not written.");

  lock_sticky_a: assert property (@(posedge pclk) disable iff (!presetn) // see RQ4
    cap.lock |=> cap.lock)
    else $error("Lock bit cleared without reset.");

  locked_write_a: assert property (@(posedge pclk) disable iff (!presetn) // see RQ4
    (cap.lock && psel && !penable && pwrite && paddr == dpl_pkg::CAP_CTRL_LO)
      |=> (pready && !pslverr && cap.lock))
    else $error("Locked write not answered quietly.");

  cap_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // see RQ4
    !wr_cap |=> $stable(cap))
    else $error("Cap control changed without a write.");

  enable_copy_a: assert property (@(posedge pclk) disable iff (!presetn) // see RQ2
    1'b1 |=> (cap_active == $past(cap.enable)))
    else $error("Cap active does not follow enable.");

  window_off_a: assert property (@(posedge pclk) disable iff (!presetn) // see RQ2
    !cap.enable |=> !over_limit)
    else $error("Window verdict kept with cap disabled.");

  throttle_cause_a: assert property (@(posedge pclk) disable iff (!presetn) // see RQ5
    throttle_out |-> $past(cap.enable && over_limit))
    else $error("Throttle without an enabled cap over budget.");

  range_hi_read_a: assert property (@(posedge pclk) disable iff (!presetn) // see RQ10 see RQ11
    (psel && !penable && !pwrite && paddr == dpl_pkg::RANGE_HI)
      |=> (prdata[14:0] == dpl_pkg::MAX_POWER && prdata[21:16] == dpl_pkg::MAX_WINDOW))
    else $error("Range info upper word read wrong.");

  // ************************************************************
  // Counter checks.
  // ************************************************************
  energy_step_a: assert property (@(posedge pclk) disable iff (!presetn) // see RQ15
    unit_tick
      |=> (energy_live == $past(energy_live) + 32'($past(sense.power))))
    else $error("Energy did not add one unit of power.");

  energy_idle_a: assert property (@(posedge pclk) disable iff (!presetn) // see RQ6
    !unit_tick |=> $stable(energy_live))
    else $error("Energy moved between time units.");

  energy_refresh_a: assert property (@(posedge pclk) disable iff (!presetn) // see RQ7
    (refresh_cnt == 32'(dpl_pkg::REFRESH_CYCLES - 1))
      |=> (energy_shown == $past(energy_live)))
    else $error("Energy snapshot not taken.");

  refresh_wrap_a: assert property (@(posedge pclk) disable iff (!presetn) // see RQ7
    (refresh_cnt == 32'(dpl_pkg::REFRESH_CYCLES - 1))
      |=> (refresh_cnt == 32'h0))
    else $error("Refresh period did not restart.");

  ro_write_a: assert property (@(posedge pclk) disable iff (!presetn) // see RQ6
    (psel && penable && pwrite && paddr == dpl_pkg::ENERGY_LO
      && refresh_cnt != 32'(dpl_pkg::REFRESH_CYCLES - 1))
      |=> $stable(energy_shown))
    else $error("Energy counter took a write.");

  unit_tick_a: assert property (@(posedge pclk) disable iff (!presetn) // see RQ12
    unit_tick |=> (!unit_tick ##9 unit_tick))
    else $error("Time unit tick off period.");

  throttle_read_a: assert property (@(posedge pclk) disable iff (!presetn) // see RQ12
    (psel && !penable && !pwrite && paddr == dpl_pkg::THROTTLE_LO)
      |=> (prdata == $past(throttle_time)))
    else $error("Throttle time read wrong.");

  throttle_idle_a: assert property (@(posedge pclk) disable iff (!presetn) // see RQ13
    !sense.throttle_req |=> $stable(throttle_time))
    else $error("Throttle time counted without a request.");

endmodule : dpl_regs

// File: dv/dpl_regs_bench.sv
// Self-checking bench for the DRAM power cap register bank.
module dpl_regs_bench;
  timeunit 1ns;
  timeprecision 1ns;
  // ************************************************************
  // Signals and expectation queue.
  // ************************************************************
  typedef struct {string nm; logic [31:0] lo; logic [31:0] hi; logic err;} dpl_exp_t;
  logic                pclk = 1'b0;
  logic                presetn = 1'b0;
  logic                psel = 1'b0;
  logic                penable = 1'b0;
  logic                pwrite = 1'b0;
  logic [7:0]          paddr = 8'h00;
  logic [31:0]         pwdata = 32'h0000_0000;
  logic [3:0]          pstrb = 4'hF;
  logic                pready;
  logic [31:0]         prdata;
  logic                pslverr;
  dpl_pkg::dpl_sense_t sense_in = '0;
  logic                throttle_out;
  logic                cap_active;
  dpl_exp_t            exp_q[$];
  int                  error_cnt = 0;
  int                  samples_checked = 0;
  logic [31:0]         seed = 32'h2A66_BB64;
  logic [31:0]         val;
  logic [15:0]         pwr;
  always #50 pclk = ~pclk;
  dpl_regs uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .sense_in(sense_in),
    .throttle_out(throttle_out), .cap_active(cap_active));
  // ************************************************************
  // Tasks.
  // ************************************************************
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xorshift
  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run
  task automatic check_val(input string nm, input logic [31:0] lo, input logic [31:0] hi,
                           input logic [31:0] got);
    samples_checked++;
    if (((got >= lo) && (got <= hi)) !== 1'b1) begin
      error_cnt++;
      $display("mismatch %s expected %h..%h seen %h", nm, lo, hi, got);
    end
  endtask : check_val
  // Every transfer notes its expectation; writes only expect the error flag.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] lo, input logic [31:0] hi, input logic err);
    int n;
    n = 0;
    exp_q.push_back('{$sformatf("addr %h", a), lo, hi, err});
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge pclk);
    end
    if (n == 20) begin
      error_cnt++;
    end
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] lo, input logic [31:0] hi);
    apb(1'b0, a, 32'h0000_0000, lo, hi, 1'b0);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0000_0000, 32'hFFFF_FFFF, 1'b0);
  endtask : wr
  // ************************************************************
  // Response watcher.
  // ************************************************************
  always @(posedge pclk) begin
    dpl_exp_t e;
    if (psel && penable && pready === 1'b1 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      check_val(e.nm, e.lo, e.hi, prdata);
      check_val({e.nm, " error"}, {31'h0, e.err}, {31'h0, e.err}, {31'h0, pslverr});
    end
  end
  initial begin
    #(40_000 * 100);
    error_cnt++;
    complete_run();
  end
  // ************************************************************
  // Main sequence.
  // ************************************************************
  initial begin
    seed = xorshift(seed);
    pwr = (seed[15:0] & 16'h00FF) | 16'h0001;
    sense_in.power <= pwr;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(dpl_pkg::CAP_CTRL_LO, dpl_pkg::CAP_CTRL_RESET, dpl_pkg::CAP_CTRL_RESET);
    wr(dpl_pkg::RANGE_LO, 32'hFFFF_FFFF);
    wr(dpl_pkg::ENERGY_LO, 32'hFFFF_FFFF);
    wr(dpl_pkg::THROTTLE_LO, 32'hFFFF_FFFF);
    val = {1'b0, dpl_pkg::MIN_POWER, 1'b0, dpl_pkg::TDP_POWER};
    rd(dpl_pkg::RANGE_LO, val, val);
    val = {10'h000, dpl_pkg::MAX_WINDOW, 1'b0, dpl_pkg::MAX_POWER};
    rd(dpl_pkg::RANGE_HI, val, val);
    rd(dpl_pkg::ENERGY_LO, 32'h0000_0000, 32'h0000_0000);
    rd(dpl_pkg::THROTTLE_LO, 32'h0000_0000, 32'h0000_0000);
    apb(1'b0, 8'h28, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 1'b1);
    $display("test reset and read-only done");
    for (int i = 0; i < 4; i++) begin
      seed = xorshift(seed);
      val = seed & 32'h7FFF_FFFF;
      wr(dpl_pkg::CAP_CTRL_LO, val);
      val = val & dpl_pkg::CAP_CTRL_WMASK;
      rd(dpl_pkg::CAP_CTRL_LO, val, val);
      check_val("cap_active", {31'h0, val[15]}, {31'h0, val[15]}, {31'h0, cap_active});
    end
    $display("test cap fields done");
    repeat (14_000) @(posedge pclk);
    // The snapshot taken at one millisecond holds about a thousand time units of power.
    rd(dpl_pkg::ENERGY_LO, pwr * 990, pwr * 1001);
    $display("test energy done");
    sense_in.power <= 16'h0FFF;
    wr(dpl_pkg::CAP_CTRL_LO, 32'h0000_8001);
    repeat (300) @(posedge pclk);
    check_val("throttle_out", 32'h1, 32'h1, {31'h0, throttle_out});
    rd(dpl_pkg::STATUS_REG, 32'h0000_0003, 32'h0000_0003);
    rd(dpl_pkg::THROTTLE_LO, 32'h0000_0000, 32'h0000_0000);
    sense_in.throttle_req <= 1'b1;
    repeat (1000) @(posedge pclk);
    rd(dpl_pkg::THROTTLE_LO, 32'h0000_0001, 32'h0000_0064);
    rd(dpl_pkg::SAMPLE_REG, 32'h0001_0FFF, 32'h0001_0FFF);
    $display("test throttle done");
    wr(dpl_pkg::CAP_CTRL_LO, 32'h8020_8001);
    wr(dpl_pkg::CAP_CTRL_LO, 32'h0000_0000);
    rd(dpl_pkg::CAP_CTRL_LO, 32'h8020_8001, 32'h8020_8001);
    check_val("cap_active", 32'h1, 32'h1, {31'h0, cap_active});
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    wr(dpl_pkg::CAP_CTRL_LO, 32'h0000_0005);
    rd(dpl_pkg::CAP_CTRL_LO, 32'h0000_0005, 32'h0000_0005);
    check_val("cap_active", 32'h0, 32'h0, {31'h0, cap_active});
    $display("test lock done");
    complete_run();
  end
endmodule : dpl_regs_bench
